// *** dv/option_byte_config_decoder_tb.sv ***
// Self-checking bench for the option byte decoder
`timescale 1ns/1ps
`default_nettype none
module option_byte_config_decoder_tb
  import option_cfg_pkg::*;
();
  logic        clk_in;
  logic        rst_n_in;
  logic        boot_swap_in;
  logic [15:0] nvm_addr;
  logic        nvm_rd;
  logic [7:0]  nvm_data;
  logic        auth_fail_in;
  config_type  cfg;
  logic        cfg_valid;
  logic        erase;
  logic [7:0]  reg_addr_in;
  logic [7:0]  reg_wdata_in;
  logic        reg_wr_in;
  logic        reg_rd_in;
  logic [7:0]  rdata;
  logic        irq;
  logic [7:0]  d;
  int          mismatches;
  int          checks;

  option_byte_config_decoder dut_u (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .boot_swap_in(boot_swap_in),
    .nvm_addr_out(nvm_addr), .nvm_rd_out(nvm_rd), .nvm_data_in(nvm_data),
    .auth_fail_in(auth_fail_in), .config_out(cfg),
    .config_valid_out(cfg_valid), .flash_erase_out(erase),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(rdata), .irq_out(irq));

  option_nvm_model nvm_u (
    .clk_in(clk_in), .nvm_addr_in(nvm_addr), .nvm_rd_in(nvm_rd),
    .nvm_data_out(nvm_data));

  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end

  task automatic chk(input string n, input logic [31:0] e, g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, v);
    @(posedge clk_in);
    reg_wr_in    <= 1'b1;
    reg_addr_in  <= a;
    reg_wdata_in <= v;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
    #1;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge clk_in);
    reg_rd_in   <= 1'b1;
    reg_addr_in <= a;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic load(input logic [7:0] det, osc, dbg, aosc,
                      input logic sw);
    int n;
    @(posedge clk_in);
    rst_n_in     <= 1'b0;
    boot_swap_in <= sw;
    nvm_u.mem[9'h0c1] = det;
    nvm_u.mem[9'h1c1] = det;
    nvm_u.mem[9'h0c2] = osc;
    nvm_u.mem[9'h1c2] = aosc;
    nvm_u.mem[9'h0c3] = dbg;
    nvm_u.mem[9'h1c3] = dbg;
    repeat (12) @(posedge clk_in);
    chk("cfg_in_reset", 0, cfg);
    rst_n_in <= 1'b1;
    n = 0;
    while (cfg_valid !== 1'b1 && n < 40) begin
      @(posedge clk_in);
      n++;
    end
    #1;
    chk("valid", 1, cfg_valid);
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_detector();
    logic [4:0] t [14] = '{5'h03, 5'h02, 5'h07, 5'h06, 5'h05, 5'h0b,
      5'h0a, 5'h09, 5'h0f, 5'h0e, 5'h0d, 5'h04, 5'h08, 5'h0c};
    for (int i = 0; i < 14; i++) begin
      load({t[i][4:2], 1'b1, t[i][1:0], 2'h3}, 8'he8, 8'h85, 8'he8, 0);
      chk("det_on", 1, cfg.detector_on);
      chk("det_level", i, cfg.detector_level);
      rd(REG_STATUS);
      chk("det_bad", 0, d[ST_DET_BAD]);
    end
    for (int m = 1; m < 4; m += 2) begin
      load(8'hd0 | m[7:0], 8'he8, 8'h85, 8'he8, 0);
      chk("det_off", 0, cfg.detector_on);
      rd(REG_STATUS);
      chk("det_off_bad", 0, d[ST_DET_BAD]);
    end
    load(8'h13, 8'he8, 8'h85, 8'he8, 0);
    rd(REG_STATUS);
    chk("det_prohib", 1, d[ST_DET_BAD]);
    $display("detector test done");
  endtask

  // Table entry: flash mode, frequency code, expected MHz
  task automatic t_osc();
    logic [13:0] t [9] = '{{2'h3, 4'h8, 8'h20}, {2'h3, 4'h0, 8'h18},
      {2'h3, 4'h9, 8'h10}, {2'h3, 4'h1, 8'h0c}, {2'h2, 4'ha, 8'h08},
      {2'h2, 4'hb, 8'h04}, {2'h0, 4'hd, 8'h01}, {2'h1, 4'hb, 8'h04},
      {2'h3, 4'h2, 8'h00}};
    logic [7:0] b;
    for (int i = 0; i < 9; i++) begin
      b = {t[i][13:12], 2'h2, t[i][11:8]};
      load(8'h1f, b, 8'h85, b, 0);
      chk("osc_mhz", t[i][7:0], cfg.osc_mhz);
      chk("flash_mode", t[i][13:12], cfg.flash_mode);
      rd(REG_STATUS);
      chk("flash_bad", t[i][13:12] == 2'h1, d[ST_FLASH_BAD]);
      chk("freq_bad", t[i][7:0] == 8'h00, d[ST_FREQ_BAD]);
      rd(REG_OSC_FLASH);
      chk("osc_byte", b, d);
    end
    load(8'h1f, 8'hf8, 8'h85, 8'hf8, 0);
    rd(REG_STATUS);
    chk("osc_fixed", 1, d[ST_FLASH_BAD]);
    $display("oscillator test done");
  endtask

  task automatic t_debug();
    logic en;
    logic er;
    for (int k = 0; k < 4; k++) begin
      en = k[1];
      er = k[0];
      load(8'h1f, 8'he8, {en, 6'h02, er}, 8'he8, 0);
      chk("dbg_en", en, cfg.debug_enable);
      chk("erase_pol", en & ~er, cfg.erase_on_auth_fail);
      @(posedge clk_in);
      auth_fail_in <= 1'b1;
      @(posedge clk_in);
      auth_fail_in <= 1'b0;
      #1 chk("erase", en & ~er, erase);
      rd(REG_STATUS);
      chk("dbg_bad", k == 1, d[ST_DBG_BAD]);
      chk("erase_st", en & ~er, d[ST_ERASE]);
    end
    load(8'h1f, 8'he8, 8'h81, 8'he8, 0);
    rd(REG_STATUS);
    chk("dbg_fixed", 1, d[ST_DBG_BAD]);
    $display("debug test done");
  endtask

  task automatic t_swap();
    for (int s = 0; s < 2; s++) begin
      load(8'h1f, 8'he8, 8'h85, 8'haa, s[0]);
      rd(REG_OSC_FLASH);
      chk("swap_byte", s ? 8'haa : 8'he8, d);
      chk("swap_mhz", s ? 8'h08 : 8'h20, cfg.osc_mhz);
      rd(REG_STATUS);
      chk("mismatch", 1, d[ST_MISMATCH]);
    end
    load(8'h1f, 8'he8, 8'h85, 8'he8, 1);
    rd(REG_STATUS);
    chk("no_mismatch", 0, d[ST_MISMATCH]);
    $display("swap test done");
  endtask

  task automatic t_regs();
    config_type keep;
    int n;
    load(8'h1f, 8'he8, 8'h85, 8'he8, 0);
    rd(REG_STATUS);
    chk("status", 8'h01, d);
    wr(REG_IRQ_EN, 8'h01);
    chk("irq_on", 1, irq);
    rd(REG_IRQ_EN);
    chk("irq_en", 8'h01, d);
    wr(REG_IRQ_EN, 8'h00);
    chk("irq_masked", 0, irq);
    wr(REG_IRQ_EN, 8'h01);
    wr(REG_IRQ_CLR, 8'h01);
    chk("irq_cleared", 0, irq);
    rd(REG_STATUS);
    chk("status_clr", 8'h00, d);
    rd(8'h20);
    chk("unmapped", 8'h00, d);
    wr(REG_DEBUG, 8'h00);
    rd(REG_DEBUG);
    chk("ro_debug", 8'h85, d);
    rd(REG_CONFIG);
    chk("summary", 8'he3, d);
    rd(REG_DETECTOR);
    chk("det_byte", 8'h1f, d);
    // Storage and swap change after the load must not reach the config
    keep = cfg;
    nvm_u.mem[9'h0c2] = 8'h00;
    boot_swap_in <= 1'b1;
    n = 0;
    repeat (30) begin
      @(posedge clk_in);
      n += (nvm_rd === 1'b1);
    end
    chk("no_reload", 0, n);
    chk("cfg_held", keep, cfg);
    $display("register test done");
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    rst_n_in     = 1'b0;
    boot_swap_in = 1'b0;
    auth_fail_in = 1'b0;
    reg_addr_in  = 8'h00;
    reg_wdata_in = 8'h00;
    reg_wr_in    = 1'b0;
    reg_rd_in    = 1'b0;
    mismatches   = 0;
    checks       = 0;
    t_detector();
    t_osc();
    t_debug();
    t_swap();
    t_regs();
    end_sim();
  end

  // About forty loads of some thirty-five cycles each; generous margin
  initial begin
    repeat (20000) @(posedge clk_in);
    mismatches++;
    $display("ERROR watchdog expected done seen timeout");
    end_sim();
  end
endmodule // option_byte_config_decoder_tb
`default_nettype wire

// *** dv/option_nvm_model.sv ***
// Behavioural option byte storage that answers the decoder's reads
`timescale 1ns/1ps
`default_nettype none
module option_nvm_model (
  input  wire logic        clk_in,
  input  wire logic [15:0] nvm_addr_in,
  input  wire logic        nvm_rd_in,
  output logic [7:0]       nvm_data_out
);
  // Primary and alternate copies, programmed by the bench
  logic [7:0] mem [0:511];

  ////////////////////////////////////////////////////////////////////////
  // Data stands only in the cycle after a read, then toggles, so a late
  // capture cannot pass by luck on a stale byte
  always_ff @(posedge clk_in) begin
    if (nvm_rd_in) begin
      nvm_data_out <= mem[nvm_addr_in[8:0]];
    end else begin
      nvm_data_out <= ~nvm_data_out;
    end
  end
endmodule // option_nvm_model
`default_nettype wire

// *** rtl/option_byte_config_decoder.sv ***
// Option byte loader and decoder with register port and interrupt
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - In interrupt mode the detector level is one of fourteen listed level/sub-level pairs; other codes are flagged.
// - The detector is off when the low mode bit and the top level bit are both 1.
// - Flash mode code 00 is low-voltage, 10 low-speed, 11 high-speed; 01 is flagged.
// - The frequency field maps seven codes to 32..1 MHz; other codes are flagged.
// - Both copies of the oscillator byte must match; a swap selects the alternate copy.
// - Debug bits 00 disable debug, 01 is flagged, enable bit set permits debug.
// - Debug on with erase bit clear erases flash on a failed ID check.
// - Debug on with erase bit set keeps flash on a failed ID check.
// - Both copies of the debug byte must match; a swap selects the alternate copy.
module option_byte_config_decoder
  import option_cfg_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        boot_swap_in,
  output logic [15:0]      nvm_addr_out,
  output logic             nvm_rd_out,
  input  wire logic [7:0]  nvm_data_in,
  input  wire logic        auth_fail_in,
  output config_type       config_out,
  output logic             config_valid_out,
  output logic             flash_erase_out,
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic [7:0]  reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic [7:0]       reg_rdata_out,
  output logic             irq_out
);

  ////////////////////////////////////////////////////////////////////////
  // Load sequencer: six reads, primary and alternate of three bytes
  // The read strobe is registered, so one wait state sits between the
  // request and the capture of the storage answer
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_REQ  = 5'h02,
    ST_WAIT = 5'h04,
    ST_CAP  = 5'h08,
    ST_DONE = 5'h10
  } load_state_type;

  load_state_type state_reg;
  logic [2:0]     idx_reg;
  logic [7:0]     prim_reg [3];
  logic [7:0]     alt_reg  [3];
  logic           swap_reg;
  logic [1:0]     byte_sel;
  logic           is_alt;

  assign byte_sel = idx_reg[2:1];
  assign is_alt   = idx_reg[0];

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg <= ST_IDLE;
      idx_reg   <= 3'h0;
    end else begin
      case (state_reg)
        ST_IDLE: state_reg <= ST_REQ;
        ST_REQ:  state_reg <= ST_WAIT;
        ST_WAIT: state_reg <= ST_CAP;
        ST_CAP: begin
          if (idx_reg == 3'h5) begin
            state_reg <= ST_DONE;
          end else begin
            idx_reg   <= idx_reg + 3'h1;
            state_reg <= ST_REQ;
          end
        end
        ST_DONE: state_reg <= ST_DONE;
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Swap strap sampled by a clocked process after reset release
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      swap_reg <= 1'b0;
    end else if (state_reg == ST_IDLE) begin
      swap_reg <= boot_swap_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      nvm_addr_out <= 16'h0000;
      nvm_rd_out   <= 1'b0;
    end else begin
      nvm_rd_out   <= (state_reg == ST_REQ);
      nvm_addr_out <= DETECTOR_OPTION_ADDR + {14'h0000, byte_sel}
                      + (is_alt ? ALT_COPY_OFFSET : 16'h0000);
    end
  end

  // Strobe stands in ST_WAIT; the storage answer stands in ST_CAP
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < 3; i++) begin
        prim_reg[i] <= 8'h00;
        alt_reg[i]  <= 8'h00;
      end
    end else if (state_reg == ST_CAP) begin
      if (is_alt) alt_reg[byte_sel]  <= nvm_data_in;
      else        prim_reg[byte_sel] <= nvm_data_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Decode of the selected copy
  logic [7:0] det_byte;
  logic [7:0] osc_byte;
  logic [7:0] dbg_byte;
  logic       loaded;

  // Swap exchanges the copies, so the alternate one becomes active
  assign det_byte = swap_reg ? alt_reg[0] : prim_reg[0];
  assign osc_byte = swap_reg ? alt_reg[1] : prim_reg[1];
  assign dbg_byte = swap_reg ? alt_reg[2] : prim_reg[2];
  assign loaded   = (state_reg == ST_DONE);

  logic [2:0] det_level;
  logic [1:0] det_sub;
  logic [4:0] level_idx;
  logic       det_off;
  logic       det_bad;

  assign det_level = det_byte[DET_LEVEL_LSB +: 3];
  assign det_sub   = det_byte[DET_SUB_LSB +: 2];
  assign det_off   = det_byte[DET_MODE_LO_BIT] & det_byte[DET_LEVEL_TOP];

  // Index 0 = 1.67/1.63 V up to 13 = 4.06/3.98 V
  always_comb begin
    level_idx = 5'h1f;
    if (det_byte[DET_MODE_HI_BIT] && det_byte[DET_MODE_LO_BIT]) begin
      case ({det_level, det_sub})
        5'h03:   level_idx = 5'h00;
        5'h02:   level_idx = 5'h01;
        5'h07:   level_idx = 5'h02;
        5'h06:   level_idx = 5'h03;
        5'h05:   level_idx = 5'h04;
        5'h0b:   level_idx = 5'h05;
        5'h0a:   level_idx = 5'h06;
        5'h09:   level_idx = 5'h07;
        5'h0f:   level_idx = 5'h08;
        5'h0e:   level_idx = 5'h09;
        5'h0d:   level_idx = 5'h0a;
        5'h04:   level_idx = 5'h0b;
        5'h08:   level_idx = 5'h0c;
        5'h0c:   level_idx = 5'h0d;
        default: level_idx = 5'h1f;
      endcase
    end
  end
  assign det_bad = !det_off && (level_idx > DET_LEVEL_MAX);

  flash_mode_type flash_mode;
  logic [3:0]     freq_code;
  logic [7:0]     osc_mhz;
  logic           flash_bad;
  logic           freq_bad;

  assign flash_mode = flash_mode_type'(osc_byte[FLASH_MODE_LSB +: 2]);
  assign flash_bad  = (flash_mode == FLASH_PROHIBITED)
                      || !osc_byte[OSC_FIXED_HI_BIT] || osc_byte[OSC_FIXED_LO_BIT];
  assign freq_code  = osc_byte[FREQ_SEL_LSB +: 4];

  always_comb begin
    case (freq_code)
      FREQ_32MHZ: osc_mhz = 8'h20;
      FREQ_24MHZ: osc_mhz = 8'h18;
      FREQ_16MHZ: osc_mhz = 8'h10;
      FREQ_12MHZ: osc_mhz = 8'h0c;
      FREQ_8MHZ:  osc_mhz = 8'h08;
      FREQ_4MHZ:  osc_mhz = 8'h04;
      FREQ_1MHZ:  osc_mhz = 8'h01;
      default:    osc_mhz = 8'h00;
    endcase
  end
  assign freq_bad = (osc_mhz == 8'h00);

  logic dbg_en;
  logic dbg_keep;
  logic dbg_bad;

  assign dbg_en   = dbg_byte[DBG_ENABLE_BIT];
  assign dbg_keep = dbg_byte[DBG_ERASE_BIT];
  // Enable clear with erase bit set is prohibited, as is a wrong fixed field
  assign dbg_bad  = (!dbg_en && dbg_keep)
                    || (dbg_byte[6:1] != DBG_FIXED_PATTERN);

  logic mismatch;
  assign mismatch = (prim_reg[1] != alt_reg[1]) || (prim_reg[2] != alt_reg[2]);

  ////////////////////////////////////////////////////////////////////////
  // Configuration held until next reset
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      config_out       <= '0;
      config_valid_out <= 1'b0;
    end else if (loaded && !config_valid_out) begin
      config_valid_out            <= 1'b1;
      config_out.detector_on      <= !det_off;
      config_out.detector_level   <= det_off ? 5'h00 : level_idx;
      config_out.osc_mhz          <= osc_mhz;
      config_out.flash_mode       <= flash_mode;
      config_out.debug_enable     <= dbg_en && !dbg_bad;
      config_out.erase_on_auth_fail <= dbg_en && !dbg_keep;
    end
  end

  // Erase only when debug is permitted and erase bit is clear
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      flash_erase_out <= 1'b0;
    end else begin
      flash_erase_out <= auth_fail_in && config_valid_out
                         && config_out.debug_enable
                         && config_out.erase_on_auth_fail;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Status, enable and interrupt
  logic [STATUS_W-1:0] status_reg;
  logic [STATUS_W-1:0] irq_en_reg;
  logic [STATUS_W-1:0] events;
  logic                load_pulse;

  assign load_pulse = loaded && !config_valid_out;
  assign events = {flash_erase_out, load_pulse && mismatch,
                   load_pulse && dbg_bad, load_pulse && freq_bad,
                   load_pulse && flash_bad, load_pulse && det_bad, load_pulse};

  // Set wins over a clear in the same cycle
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      status_reg <= '0;
    end else begin
      status_reg <= (status_reg & ~((reg_wr_in && reg_addr_in == REG_IRQ_CLR)
                    ? reg_wdata_in[STATUS_W-1:0] : '0)) | events;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_en_reg <= '0;
    end else if (reg_wr_in && reg_addr_in == REG_IRQ_EN) begin
      irq_en_reg <= reg_wdata_in[STATUS_W-1:0];
    end
  end

  assign irq_out = |(status_reg & irq_en_reg);

  ////////////////////////////////////////////////////////////////////////
  // Register read port, data one cycle after strobe
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        REG_DETECTOR:  reg_rdata_out <= det_byte;
        REG_OSC_FLASH: reg_rdata_out <= osc_byte;
        REG_DEBUG:     reg_rdata_out <= dbg_byte;
        REG_STATUS:    reg_rdata_out <= {1'b0, status_reg};
        REG_IRQ_EN:    reg_rdata_out <= {1'b0, irq_en_reg};
        REG_CONFIG:    reg_rdata_out <= {config_valid_out, config_out.detector_on,
                                         config_out.debug_enable,
                                         config_out.erase_on_auth_fail,
                                         2'h0, config_out.flash_mode};
        default:       reg_rdata_out <= 8'h00;
      endcase
    end else begin
      reg_rdata_out <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  property p_hold_config;
    @(posedge clk_in) disable iff (!rst_n_in)
      config_valid_out |=> config_valid_out && $stable(config_out);
  endproperty
  a_hold_config: assert property (p_hold_config) else $error("config changed");

  property p_load_time;
    @(posedge clk_in) disable iff (!rst_n_in)
      $rose(config_valid_out) |-> state_reg == ST_DONE && idx_reg == 3'h5;
  endproperty
  a_load_time: assert property (p_load_time) else $error("early load");

  property p_no_erase_keep;
    @(posedge clk_in) disable iff (!rst_n_in)
      flash_erase_out |-> !config_out.erase_on_auth_fail == 1'b0 && $past(auth_fail_in);
  endproperty
  a_no_erase_keep: assert property (p_no_erase_keep) else $error("bad erase");

  property p_erase;
    @(posedge clk_in) disable iff (!rst_n_in)
      auth_fail_in && config_valid_out && config_out.debug_enable
      && config_out.erase_on_auth_fail |=> flash_erase_out;
  endproperty
  a_erase: assert property (p_erase) else $error("erase missed");

  property p_det_off;
    @(posedge clk_in) disable iff (!rst_n_in)
      $rose(config_valid_out) |-> config_out.detector_on
        == !$past(det_byte[DET_MODE_LO_BIT] & det_byte[DET_LEVEL_TOP]);
  endproperty
  a_det_off: assert property (p_det_off) else $error("detector off");

  property p_flash_bad;
    @(posedge clk_in) disable iff (!rst_n_in)
      load_pulse && flash_mode == FLASH_PROHIBITED |=> status_reg[ST_FLASH_BAD];
  endproperty
  a_flash_bad: assert property (p_flash_bad) else $error("flash code");

  property p_freq;
    @(posedge clk_in) disable iff (!rst_n_in)
      load_pulse && freq_code == FREQ_1MHZ |=> config_out.osc_mhz == 8'h01;
  endproperty
  a_freq: assert property (p_freq) else $error("freq map");

  property p_dbg_off;
    @(posedge clk_in) disable iff (!rst_n_in)
      load_pulse && !dbg_en |=> !config_out.debug_enable;
  endproperty
  a_dbg_off: assert property (p_dbg_off) else $error("debug on");

  property p_level;
    @(posedge clk_in) disable iff (!rst_n_in)
      load_pulse && !det_off |=> status_reg[ST_DET_BAD]
        || config_out.detector_level <= DET_LEVEL_MAX;
  endproperty
  a_level: assert property (p_level) else $error("level range");

  c_loaded:   cover property (@(posedge clk_in) $rose(config_valid_out));
  c_swap:     cover property (@(posedge clk_in) config_valid_out && swap_reg);
  c_erase:    cover property (@(posedge clk_in) flash_erase_out);
  c_mismatch: cover property (@(posedge clk_in) status_reg[ST_MISMATCH]);

endmodule // option_byte_config_decoder
`default_nettype wire

// *** rtl/option_cfg_pkg.sv ***
// Package: option byte offsets, field positions, encodings and register map
package option_cfg_pkg;

  // Option byte storage offsets (primary and alternate copies)
  localparam logic [15:0] DETECTOR_OPTION_ADDR     = 16'h00c1;
  localparam logic [15:0] OSC_FLASH_OPTION_ADDR    = 16'h00c2;
  localparam logic [15:0] DEBUG_OPTION_ADDR        = 16'h00c3;
  localparam logic [15:0] ALT_COPY_OFFSET          = 16'h0100;

  // Detector option byte fields
  localparam int DET_MODE_LO_BIT  = 0;
  localparam int DET_MODE_HI_BIT  = 1;
  localparam int DET_SUB_LSB      = 2;
  localparam int DET_LEVEL_LSB    = 5;
  localparam int DET_LEVEL_TOP    = 7;
  localparam logic [4:0] DET_LEVEL_MAX = 5'h0d;

  // Oscillator / flash option byte fields
  localparam int FLASH_MODE_LSB   = 6;
  localparam int FREQ_SEL_LSB     = 0;
  localparam int OSC_FIXED_HI_BIT = 5;
  localparam int OSC_FIXED_LO_BIT = 4;

  // Debug option byte fields
  localparam int DBG_ENABLE_BIT   = 7;
  localparam int DBG_ERASE_BIT    = 0;
  localparam logic [5:0] DBG_FIXED_PATTERN = 6'h02;

  typedef enum logic [1:0] {
    FLASH_LOW_VOLTAGE = 2'h0,
    FLASH_PROHIBITED  = 2'h1,
    FLASH_LOW_SPEED   = 2'h2,
    FLASH_HIGH_SPEED  = 2'h3
  } flash_mode_type;

  // Oscillator frequency select codes
  localparam logic [3:0] FREQ_32MHZ = 4'h8;
  localparam logic [3:0] FREQ_24MHZ = 4'h0;
  localparam logic [3:0] FREQ_16MHZ = 4'h9;
  localparam logic [3:0] FREQ_12MHZ = 4'h1;
  localparam logic [3:0] FREQ_8MHZ  = 4'ha;
  localparam logic [3:0] FREQ_4MHZ  = 4'hb;
  localparam logic [3:0] FREQ_1MHZ  = 4'hd;

  // Decoded configuration handed to clock, detector and debug logic
  typedef struct packed {
    logic           detector_on;
    logic [4:0]     detector_level;
    logic [7:0]     osc_mhz;
    flash_mode_type flash_mode;
    logic           debug_enable;
    logic           erase_on_auth_fail;
  } config_type;

  // Software register map
  localparam logic [7:0] REG_DETECTOR  = 8'hc1;
  localparam logic [7:0] REG_OSC_FLASH = 8'hc2;
  localparam logic [7:0] REG_DEBUG     = 8'hc3;
  localparam logic [7:0] REG_STATUS    = 8'h10;
  localparam logic [7:0] REG_IRQ_EN    = 8'h14;
  localparam logic [7:0] REG_IRQ_CLR   = 8'h18;
  localparam logic [7:0] REG_CONFIG    = 8'h1c;

  // Status bit positions
  localparam int ST_LOADED     = 0;
  localparam int ST_DET_BAD    = 1;
  localparam int ST_FLASH_BAD  = 2;
  localparam int ST_FREQ_BAD   = 3;
  localparam int ST_DBG_BAD    = 4;
  localparam int ST_MISMATCH   = 5;
  localparam int ST_ERASE      = 6;
  localparam int STATUS_W      = 7;

endpackage : option_cfg_pkg
